// ===== core/flash_host_defs.svh
// Constants for the parallel flash host controller.
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH
// Command cycle addresses and data codes.
`define CMD_ADDR_A 12'h0555
`define CMD_ADDR_B 12'h0AAA
`define CMD_DATA_AA 8'hAA
`define CMD_DATA_55 8'h55
`define CMD_DATA_80 8'h80
`define CMD_DATA_A0 8'hA0
`define CMD_DATA_CHIP 8'h10
`define CMD_DATA_SECTOR 8'h30
`define CMD_DATA_LOCK 8'h40
`define ERASED_BYTE 8'hFF
// Bit positions for completion polling; the controller tests bit 6 only.
`define POLL_BIT7 7
`define POLL_BIT6 6
// Strobe timing in 8 ns clock cycles.
`define CLK_PERIOD_NS 8
`define SETUP_NS 40
`define SETUP_CYC ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_NS 40
`define PULSE_CYC ((`PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_NS 16
`define HOLD_CYC ((`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_NS 56
`define READ_CYC ((`READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_LOW_NS 504
`define RESET_LOW_CYC ((`RESET_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W 8
`endif

// ===== core/flash_host_pkg.sv
// Types shared by the parallel flash host controller.
package flash_host_pkg;
    // Operations the user may request.
    typedef enum logic [2:0]
    {
        OP_READ = 3'h0,
        OP_PROGRAM = 3'h1,
        OP_SECTOR_ERASE = 3'h2,
        OP_CHIP_ERASE = 3'h3,
        OP_LOCKOUT = 3'h4,
        OP_RESET = 3'h5
    } op_t;

    // One user request.
    typedef struct packed
    {
        op_t op;
        logic [16:0] addr;
        logic [7:0] data;
    } req_t;

    // Pins driven toward the flash.
    typedef struct packed
    {
        logic [16:0] addr;
        logic [7:0] dq;
        logic dq_oe_n;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic reset_n;
    } pins_t;

    // Controller states, Gray coded along the write path.
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_PULSE = 3'b011,
        ST_HOLD = 3'b010,
        ST_POLL = 3'b110,
        ST_READ = 3'b111,
        ST_RST = 3'b101
    } state_t;
endpackage : flash_host_pkg

// ===== core/flash_host.sv
// Host-side controller that drives a byte-wide parallel flash through its pins.
`timescale 1ns/1ns
`include "flash_host_defs.svh"
module flash_host
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire flash_host_pkg::req_t req_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    output logic [7:0] rd_data_o,
    output logic done_o,
    output logic mismatch_o,
    output flash_host_pkg::pins_t pins_o,
    input wire logic [7:0] dq_i
);
    // ****************************************
    // Command sequence table
    // ****************************************
    // Returns the address of step k of a sequence; the last step of program and sector erase
    // carries the target address instead.
    function automatic logic [16:0] seq_addr(input flash_host_pkg::req_t r, input logic [2:0] k);
        logic last;
        last = (r.op == flash_host_pkg::OP_PROGRAM) ? (k == 3'h3) : (k == 3'h5);
        if (last && (r.op == flash_host_pkg::OP_PROGRAM || r.op == flash_host_pkg::OP_SECTOR_ERASE))
            return r.addr;
        else if (k == 3'h1 || k == 3'h4)
            return {5'h00, `CMD_ADDR_B};
        else
            return {5'h00, `CMD_ADDR_A};
    endfunction : seq_addr
    // Returns the data of step k of a sequence.
    function automatic logic [7:0] seq_data(input flash_host_pkg::req_t r, input logic [2:0] k);
        logic [7:0] d;
        d = `CMD_DATA_AA;
        case (k)
            3'h1, 3'h4: d = `CMD_DATA_55;
            3'h2: d = (r.op == flash_host_pkg::OP_PROGRAM) ? `CMD_DATA_A0 : `CMD_DATA_80;
            3'h3: d = (r.op == flash_host_pkg::OP_PROGRAM) ? r.data : `CMD_DATA_AA;
            3'h5: d = (r.op == flash_host_pkg::OP_CHIP_ERASE) ? `CMD_DATA_CHIP
                      : (r.op == flash_host_pkg::OP_SECTOR_ERASE) ? `CMD_DATA_SECTOR : `CMD_DATA_LOCK;
            default: d = `CMD_DATA_AA;
        endcase
        return d;
    endfunction : seq_data
    // ****************************************
    // State
    // ****************************************
    flash_host_pkg::state_t state, next_state; // Controller state and its next value.
    flash_host_pkg::req_t cur, next_cur; // Request being served.
    logic [2:0] step, next_step; // Write cycle within the sequence; 7 marks a poll gap.
    logic [`TIMER_W-1:0] timer, next_timer; // Phase timer in clock cycles.
    logic [7:0] last_poll, next_last_poll; // Previous polled byte, for bit 6 toggle detection.
    logic poll_seen, next_poll_seen; // A first poll sample is held.
    logic [7:0] rd_data, next_rd_data; // Read data or final poll byte.
    logic done, next_done; // One-cycle completion pulse.
    logic mismatch, next_mismatch; // Result differs from what was asked.
    logic [2:0] last_step; // Final write step for the current operation.
    assign last_step = (cur.op == flash_host_pkg::OP_PROGRAM) ? 3'h3 : 3'h5;
    // ****************************************
    // Next-state logic
    // ****************************************
    // One request at a time; a new one is only taken in idle, which is how the host waits
    // for each program or erase to finish before its next access.
    always_comb
    begin
        next_state = state;
        next_cur = cur;
        next_step = step;
        next_timer = (timer == '0) ? timer : timer - 1'b1;
        next_last_poll = last_poll;
        next_poll_seen = poll_seen;
        next_rd_data = rd_data;
        next_done = 1'b0;
        next_mismatch = mismatch;
        unique case (state)
            flash_host_pkg::ST_IDLE:
            begin
                if (req_valid_i)
                begin
                    next_cur = req_i;
                    next_step = 3'h0;
                    next_poll_seen = 1'b0;
                    next_mismatch = 1'b0;
                    if (req_i.op == flash_host_pkg::OP_READ)
                    begin
                        next_state = flash_host_pkg::ST_READ;
                        next_timer = `TIMER_W'(`READ_CYC);
                    end
                    else if (req_i.op == flash_host_pkg::OP_RESET)
                    begin
                        next_state = flash_host_pkg::ST_RST;
                        next_timer = `TIMER_W'(`RESET_LOW_CYC);
                    end
                    else
                    begin
                        next_state = flash_host_pkg::ST_SETUP;
                        next_timer = `TIMER_W'(`SETUP_CYC);
                    end
                end
            end
            flash_host_pkg::ST_SETUP:
            begin
                // Address settles before the strobe falls, so the later falling edge sees it.
                // A poll gap (step 7) goes back to polling; it must never open a write.
                if (timer == '0)
                begin
                    next_state = (step == 3'h7) ? flash_host_pkg::ST_POLL : flash_host_pkg::ST_PULSE;
                    next_timer = (step == 3'h7) ? `TIMER_W'(`READ_CYC) : `TIMER_W'(`PULSE_CYC);
                end
            end
            flash_host_pkg::ST_PULSE:
            begin
                if (timer == '0)
                begin
                    next_state = flash_host_pkg::ST_HOLD;
                    next_timer = `TIMER_W'(`HOLD_CYC);
                end
            end
            flash_host_pkg::ST_HOLD:
            begin
                if (timer == '0)
                begin
                    if (step == last_step)
                    begin
                        // Lockout also needs no poll result; it is treated like an erase.
                        next_state = flash_host_pkg::ST_POLL;
                        next_timer = `TIMER_W'(`READ_CYC);
                    end
                    else
                    begin
                        next_step = step + 3'h1;
                        next_state = flash_host_pkg::ST_SETUP;
                        next_timer = `TIMER_W'(`SETUP_CYC);
                    end
                end
            end
            flash_host_pkg::ST_POLL:
            begin
                // Each poll is one full read strobe, so bit 6 advances once per poll.
                if (timer == '0)
                begin
                    next_last_poll = dq_i;
                    next_poll_seen = 1'b1;
                    if (poll_seen && (dq_i[`POLL_BIT6] == last_poll[`POLL_BIT6]))
                    begin
                        next_state = flash_host_pkg::ST_IDLE;
                        next_done = 1'b1;
                        next_rd_data = dq_i;
                        // A program that cleared no bit it should have shows as a mismatch.
                        if (cur.op == flash_host_pkg::OP_PROGRAM)
                            next_mismatch = (dq_i != cur.data);
                        else if (cur.op == flash_host_pkg::OP_SECTOR_ERASE)
                            next_mismatch = (dq_i != `ERASED_BYTE);
                        else
                            next_mismatch = 1'b0;
                    end
                    else
                    begin
                        next_state = flash_host_pkg::ST_SETUP; // Gap between polls.
                        next_step = 3'h7;
                        next_timer = `TIMER_W'(`SETUP_CYC);
                    end
                end
            end
            flash_host_pkg::ST_READ:
            begin
                if (timer == '0)
                begin
                    next_rd_data = dq_i;
                    next_done = 1'b1;
                    next_state = flash_host_pkg::ST_IDLE;
                end
            end
            flash_host_pkg::ST_RST:
            begin
                if (timer == '0)
                begin
                    next_done = 1'b1;
                    next_state = flash_host_pkg::ST_IDLE;
                end
            end
            default: next_state = flash_host_pkg::ST_IDLE; // Unused state codes fall back to idle.
        endcase
    end
    // Registers only.
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state <= flash_host_pkg::ST_IDLE;
            cur <= '0;
            step <= 3'h0;
            timer <= '0;
            last_poll <= 8'h00;
            poll_seen <= 1'b0;
            rd_data <= 8'h00;
            done <= 1'b0;
            mismatch <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cur <= next_cur;
            step <= next_step;
            timer <= next_timer;
            last_poll <= next_last_poll;
            poll_seen <= next_poll_seen;
            rd_data <= next_rd_data;
            done <= next_done;
            mismatch <= next_mismatch;
        end
    end
    // ****************************************
    // Pin drive
    // ****************************************
    // Pins are decoded from registered state; output enable stays high on every write.
    always_comb
    begin
        pins_o.addr = (state == flash_host_pkg::ST_READ || state == flash_host_pkg::ST_POLL
                       || step == 3'h7) ? cur.addr : seq_addr(cur, step);
        pins_o.dq = seq_data(cur, step);
        pins_o.ce_n = (state == flash_host_pkg::ST_IDLE || state == flash_host_pkg::ST_RST);
        pins_o.we_n = !(state == flash_host_pkg::ST_PULSE);
        pins_o.oe_n = !(state == flash_host_pkg::ST_READ || state == flash_host_pkg::ST_POLL);
        pins_o.dq_oe_n = !(state == flash_host_pkg::ST_SETUP || state == flash_host_pkg::ST_PULSE
                           || state == flash_host_pkg::ST_HOLD) || step == 3'h7;
        pins_o.reset_n = !(state == flash_host_pkg::ST_RST);
    end
    assign req_ready_o = (state == flash_host_pkg::ST_IDLE);
    assign rd_data_o = rd_data;
    assign done_o = done;
    assign mismatch_o = mismatch;
    // ****************************************
    // Assertions
    // ****************************************
    AST_OE_HIGH_ON_WRITE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !pins_o.we_n |-> pins_o.oe_n && !pins_o.ce_n)
        else $error("Write strobe low while output enable low.");
    AST_NO_CONTENTION: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !pins_o.oe_n |-> pins_o.dq_oe_n)
        else $error("Host drives data while flash outputs enabled.");
    AST_ADDR_STABLE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !pins_o.we_n |-> $stable(pins_o.addr))
        else $error("Address moved during write pulse.");
    AST_DATA_STABLE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(pins_o.we_n) |-> $stable(pins_o.dq) && !pins_o.dq_oe_n)
        else $error("Data not held at strobe rise.");
    AST_BUSY_NO_REQ: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state == flash_host_pkg::ST_POLL |-> !req_ready_o && pins_o.we_n && pins_o.dq_oe_n)
        else $error("Ready or write while an operation is still polled.");
    AST_RESET_LEN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $fell(pins_o.reset_n) |-> !pins_o.reset_n [*8])
        else $error("Flash reset pulse too short.");
    AST_READ_DONE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $fell(pins_o.oe_n) && state == flash_host_pkg::ST_READ |-> ##[1:12] done_o)
        else $error("Read did not complete in time.");
    AST_FIRST_CODE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !pins_o.we_n && step == 3'h0 |-> pins_o.addr[11:0] == `CMD_ADDR_A && pins_o.dq == `CMD_DATA_AA)
        else $error("First command cycle wrong.");
    COV_PROGRAM: cover property (@(posedge sys_clk_i) done_o && cur.op == flash_host_pkg::OP_PROGRAM);
    COV_SECTOR: cover property (@(posedge sys_clk_i) done_o && cur.op == flash_host_pkg::OP_SECTOR_ERASE);
    COV_READ: cover property (@(posedge sys_clk_i) done_o && cur.op == flash_host_pkg::OP_READ);
endmodule : flash_host

// ===== verification/flash_device_model.sv
// Behavioural model of the byte-wide flash that the host controller drives.
`timescale 1ns/1ns
`include "flash_host_defs.svh"
module flash_device_model
#(
    parameter int BYTE_PROGRAM_TIME_NS = 2000,
    parameter int CHIP_ERASE_TIME_MAX_NS = 20000
)
(
    input wire flash_host_pkg::pins_t pins_i,
    output logic [7:0] dq_o
);
    // ****************************************
    // Array and command state
    // ****************************************
    logic [7:0] mem [0:131071]; // Array contents.
    logic [16:0] cap_addr; // Address of the open write cycle.
    logic [7:0] last_data = 8'h00; // Byte most recently programmed.
    logic [7:0] held = 8'h00; // Last driven value.
    logic in_wr = 1'b0; // A write cycle is open.
    logic busy = 1'b0; // Program or erase in flight.
    logic prog = 1'b0; // The busy operation is a program.
    logic tog = 1'b0; // Toggle bit.
    logic locked = 1'b0; // Boot block lockout is on.
    int step = 0; // Position in the command sequence.
    int dur = 0; // Busy time of the operation.
    event start_ev;
    wire rd_en = !pins_i.ce_n && !pins_i.oe_n && pins_i.we_n && pins_i.reset_n;
    wire [7:0] rd_val = !busy ? mem[pins_i.addr] :
        prog ? {~last_data[7], tog, last_data[5:0]} : {1'b0, tog, 6'h00};
    initial foreach (mem[i]) mem[i] = `ERASED_BYTE;
    // A released bus shows the inverse of its last value, so stale data never passes for fresh data.
    always @(rd_en or rd_val)
        if (rd_en) held = rd_val;
    assign dq_o = rd_en ? rd_val : ~held;
    function automatic logic hit(input logic [16:0] a, input logic [7:0] d, input logic [11:0] ca,
        input logic [7:0] cd);
        return a[11:0] == ca && d == cd;
    endfunction : hit
    task automatic erase(input int lo, input int hi);
        // No override voltage is modelled, so a set lockout always shields the boot block.
        for (int i = lo; i <= hi; i++)
            if (!(locked && i < 32'h0000_4000)) mem[i] = `ERASED_BYTE;
    endtask : erase
    // ****************************************
    // Command decode
    // ****************************************
    task automatic take(input logic [16:0] a, input logic [7:0] d);
        if (busy) return;
        case (step)
            0: step = hit(a, d, `CMD_ADDR_A, `CMD_DATA_AA) ? 1 : 0;
            1: step = hit(a, d, `CMD_ADDR_B, `CMD_DATA_55) ? 2 : 0;
            2: step = hit(a, d, `CMD_ADDR_A, `CMD_DATA_80) ? 4 : hit(a, d, `CMD_ADDR_A, `CMD_DATA_A0) ? 3 : 0;
            3:
            begin
                if (!(locked && a < 17'h0_4000)) mem[a] = mem[a] & d;
                last_data = d;
                prog = 1'b1;
                dur = BYTE_PROGRAM_TIME_NS;
                step = 0;
                ->start_ev;
            end
            4: step = hit(a, d, `CMD_ADDR_A, `CMD_DATA_AA) ? 5 : 0;
            5: step = hit(a, d, `CMD_ADDR_B, `CMD_DATA_55) ? 6 : 0;
            default:
            begin
                step = 0;
                prog = 1'b0;
                dur = CHIP_ERASE_TIME_MAX_NS;
                if (hit(a, d, `CMD_ADDR_A, `CMD_DATA_CHIP)) erase(0, 32'h0001_FFFF);
                else if (d == `CMD_DATA_SECTOR && a < 17'h0_4000) erase(0, 32'h0000_3FFF);
                else if (d == `CMD_DATA_SECTOR && a < 17'h0_6000) erase(32'h0000_4000, 32'h0000_5FFF);
                else if (d == `CMD_DATA_SECTOR && a < 17'h0_8000) erase(32'h0000_6000, 32'h0000_7FFF);
                else if (d == `CMD_DATA_SECTOR && a < 17'h1_0000) erase(32'h0000_8000, 32'h0000_FFFF);
                else if (d == `CMD_DATA_SECTOR) erase(32'h0001_0000, 32'h0001_FFFF);
                else if (hit(a, d, `CMD_ADDR_A, `CMD_DATA_LOCK)) locked = 1'b1;
                if (d == `CMD_DATA_CHIP || d == `CMD_DATA_SECTOR) ->start_ev;
            end
        endcase
    endtask : take
    // Address is taken when the later of the two strobes falls.
    always @(negedge pins_i.we_n or negedge pins_i.ce_n)
        if (!pins_i.we_n && !pins_i.ce_n && pins_i.oe_n && pins_i.reset_n)
        begin
            cap_addr = pins_i.addr;
            in_wr = 1'b1;
        end
    // Data is taken when the first of the two strobes rises.
    always @(posedge pins_i.we_n or posedge pins_i.ce_n)
        if (in_wr)
        begin
            in_wr = 1'b0;
            take(cap_addr, pins_i.dq);
        end
    // Each read started while busy flips the toggle bit.
    always @(negedge pins_i.oe_n)
        if (busy && !pins_i.ce_n) tog = ~tog;
    // Internal timer, no clock needed.
    always @(start_ev)
    begin : op_timer
        busy = 1'b1;
        #(dur);
        busy = 1'b0;
    end
    // Reset low aborts the operation and leaves the model in read mode.
    always @(negedge pins_i.reset_n)
    begin
        disable op_timer;
        busy = 1'b0;
        step = 0;
        in_wr = 1'b0;
    end
endmodule : flash_device_model

// ===== verification/flash_host_tb_top.sv
// Self-checking testbench for the parallel flash host controller.
`timescale 1ns/1ns
`include "flash_host_defs.svh"
module flash_host_tb_top;
    logic sys_clk = 1'b0; // 125 MHz clock.
    logic rst = 1'b1; // Reset, held for four cycles.
    flash_host_pkg::req_t req = '0;
    logic req_valid = 1'b0;
    logic req_ready;
    logic [7:0] rd_data;
    logic done;
    logic mismatch;
    flash_host_pkg::pins_t pins;
    logic [7:0] dq; // Value the flash puts out.
    wire [7:0] dq_bus = !pins.dq_oe_n ? pins.dq : dq; // Resolved data wire.
    int err_total = 0;
    int compares = 0;
    int lat; // Cycles from take to completion.
    int low_cnt; // Cycles with the flash reset pin low.
    initial forever #4 sys_clk = ~sys_clk;
    flash_host dut(.sys_clk_i(sys_clk), .rst_i(rst), .req_i(req), .req_valid_i(req_valid),
        .req_ready_o(req_ready), .rd_data_o(rd_data), .done_o(done), .mismatch_o(mismatch),
        .pins_o(pins), .dq_i(dq_bus));
    flash_device_model flash(.pins_i(pins), .dq_o(dq));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test
    // One request, then a bounded wait for done; erase is the longest at about 2600 cycles.
    task automatic run_op(input flash_host_pkg::op_t op, input logic [16:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{op: op, addr: a, data: d};
        req_valid <= 1'b1;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        lat = 0;
        low_cnt = 0;
        while (done !== 1'b1 && lat < 20000)
        begin
            @(posedge sys_clk);
            #1;
            lat++;
            if (pins.reset_n === 1'b0) low_cnt++;
        end
        check("request completion", done, 1'b1);
    endtask : run_op
    task automatic read_expect(input logic [16:0] a, input logic [7:0] exp);
        run_op(flash_host_pkg::OP_READ, a, 8'h00);
        check("read data", rd_data, exp);
    endtask : read_expect
    // The output enable must stay high whenever the host writes or drives data.
    // Sampled half a cycle off the launching edge so the pins have settled.
    always @(negedge sys_clk)
        if (!rst && (pins.we_n === 1'b0 || pins.dq_oe_n === 1'b0))
            check("output enable while writing", pins.oe_n, 1'b1);
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_read();
        check("ready after reset", req_ready, 1'b1);
        check("idle pins", {pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe_n, pins.reset_n}, 5'h1F);
        read_expect(17'h1_F000, `ERASED_BYTE);
        check("read latency", lat, `READ_CYC + 1);
        @(posedge sys_clk);
        #1;
        check("done pulse width", done, 1'b0);
        $display("Test read done");
    endtask : t_read
    task automatic t_program();
        run_op(flash_host_pkg::OP_PROGRAM, 17'h1_2345, 8'h5A);
        check("program result", mismatch, 1'b0);
        read_expect(17'h1_2345, 8'h5A);
        run_op(flash_host_pkg::OP_PROGRAM, 17'h1_2345, 8'hA5);
        check("program over zeros", mismatch, 1'b1);
        read_expect(17'h1_2345, 8'h00);
        read_expect(17'h0_0555, `ERASED_BYTE);
        read_expect(17'h0_0AAA, `ERASED_BYTE);
        $display("Test program done");
    endtask : t_program
    task automatic t_sector();
        run_op(flash_host_pkg::OP_PROGRAM, 17'h0_4000, 8'h11);
        run_op(flash_host_pkg::OP_PROGRAM, 17'h0_6000, 8'h22);
        run_op(flash_host_pkg::OP_SECTOR_ERASE, 17'h0_5FFF, 8'h00);
        check("sector erase result", mismatch, 1'b0);
        read_expect(17'h0_4000, `ERASED_BYTE);
        read_expect(17'h0_6000, 8'h22);
        $display("Test sector erase done");
    endtask : t_sector
    task automatic t_lock_chip();
        run_op(flash_host_pkg::OP_PROGRAM, 17'h0_0010, 8'h00);
        run_op(flash_host_pkg::OP_LOCKOUT, 17'h0_0000, 8'h00);
        run_op(flash_host_pkg::OP_PROGRAM, 17'h0_0020, 8'h3C);
        check("program into locked boot", mismatch, 1'b1);
        run_op(flash_host_pkg::OP_CHIP_ERASE, 17'h0_0000, 8'h00);
        read_expect(17'h0_0010, 8'h00);
        read_expect(17'h0_6000, `ERASED_BYTE);
        read_expect(17'h1_2345, `ERASED_BYTE);
        $display("Test lockout and chip erase done");
    endtask : t_lock_chip
    task automatic t_flash_reset();
        run_op(flash_host_pkg::OP_RESET, 17'h0_0000, 8'h00);
        check("flash reset low span", low_cnt >= `RESET_LOW_CYC, 1'b1);
        check("flash reset released", pins.reset_n, 1'b1);
        read_expect(17'h0_0010, 8'h00);
        $display("Test flash reset done");
    endtask : t_flash_reset
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        t_read();
        t_program();
        t_sector();
        t_lock_chip();
        t_flash_reset();
        finish_test();
    end
    // The tests need about 60 us; ten times that is a hang.
    initial
    begin
        #600000;
        err_total++;
        $display("Watchdog expired");
        finish_test();
    end
endmodule : flash_host_tb_top
